// ==== hw/clock_fallback_monitor.sv ====
/*
 * clock fallback monitor: pll source check, bus/compat/network clock
 * supervision, reference fallback and its register port.
 * assumes pins arrive asynchronous to clk (250 MHz) and a one-cycle
 * register master; the analog pll and muxes sit outside.
 */
// The strobed register port and the register addresses are this design's own decisions.
// Operation
// - checking starts at the role command
// - reset routes internal oscillator to pll
// - bad source: internal osc, clear, flag
// - master with slave path is an error
// - slave with master reference is error
// - failures interrupt unmasked, always pollable
// - monitoring starts once setup is completed
// - bus bit clocks late by 35ns fail
// - bus frame must hold 1024 periods
// - mvip clock late 40ns or count wrong
// - scbus clock late 40ns or count wrong
// - network reference late by 80ns fails
// - compat frame judged against active reference
// - primary master falls to secondary, returns
// - secondary master follows A, drives B
// - slave moves from A to B set
// - reference switch loses no switched data
// - pll bypassed 750us after frequency command
// - software reset leaves clocking untouched
`timescale 1ns/1ns
`include "cfm_defs.svh"
// one clock (and optional frame) supervisor
module cfm_clk_mon (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic en,
    input wire logic clkLvl,
    input wire logic frmLvl,
    input wire logic useFrame,
    input wire logic [15:0] lateLim,
    input wire logic [11:0] expCnt,
    output logic fail,
    output logic healthy
);
    import cfm_pkg::*;
    cfm_mon_s cur_r; // registered state
    cfm_mon_s cur_nxt; // next state
    logic rise; // rising clock edge seen
    // edge timing and period counting
    always_comb
    begin
        cur_nxt = cur_r;
        cur_nxt.fail = 1'b0;
        rise = clkLvl && !cur_r.prevClk;
        cur_nxt.prevClk = clkLvl;
        cur_nxt.prevFrm = frmLvl;
        if (!en)
        begin
            // idle: forget history so a restart never reports stale gaps
            cur_nxt.armed = 1'b0;
            cur_nxt.framed = 1'b0;
            cur_nxt.gap = '0;
            cur_nxt.cnt = '0;
        end
        else
        begin
            if (cur_r.gap != 16'hffff)
                cur_nxt.gap = cur_r.gap + 16'h0001;
            if (rise)
            begin
                cur_nxt.gap = '0;
                cur_nxt.armed = 1'b1;
                if (cur_r.cnt != 12'hfff)
                    cur_nxt.cnt = cur_r.cnt + 12'h001;
            end
            else if (cur_r.armed && cur_r.gap >= lateLim)
            begin
                // one report per outage; the next edge re-arms
                cur_nxt.fail = 1'b1;
                cur_nxt.armed = 1'b0;
            end
            if (useFrame && cur_r.prevFrm && !frmLvl)
            begin
                if (cur_r.framed && cur_r.cnt != expCnt)
                    cur_nxt.fail = 1'b1;
                cur_nxt.framed = 1'b1;
                cur_nxt.cnt = rise ? 12'h001 : 12'h000;
            end
        end
    end
    // state register, frozen by ce
    always_ff @(posedge clk)
    begin
        if (rst)
            cur_r <= '0;
        else if (ce)
            cur_r <= cur_nxt;
    end
    assign fail = cur_r.fail;
    assign healthy = cur_r.armed;
    a_late_edge_report: assert property (@(posedge clk) disable iff (rst)
        ce && en && cur_r.armed && cur_r.gap >= lateLim && !rise |=> fail)
        else $error("late edge not reported");
endmodule // cfm_clk_mon
// top: registers, source checking and fallback
module clock_fallback_monitor #(
    parameter int LOCK_CYCLES = `CFM_LOCK_NS / `CFM_CLK_NS,
    parameter int NET_LATE_CYC = `CFM_LATE(`CFM_NET_PS, `CFM_NET_TOL_NS)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire cfm_pkg::cfm_pins_s pins,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output cfm_pkg::cfm_gen_s gen,
    output logic irq,
    output logic swResetActive
);
    import cfm_pkg::*;
    localparam logic [15:0] BUS_LATE = 16'(`CFM_LATE(`CFM_C8_PS, `CFM_BUS_TOL_NS));
    localparam logic [15:0] NET_LATE = 16'(NET_LATE_CYC);
    localparam logic [17:0] LOCK_LAST = 18'(LOCK_CYCLES - 1);
    cfm_top_s st_r; // registered state
    cfm_top_s st_nxt; // next state
    cfm_pins_s pin; // synchronised pins
    logic fA, fB, fC, fNP, fNS; // failure pulses
    logic hNP; // primary network ref alive
    logic busEn, cmpEn, netEn; // monitor enables
    logic [1:0] rate; // effective compat rate
    logic [15:0] cmpLate; // compat edge limit
    logic [11:0] cmpCnt; // compat periods per frame
    logic cmd1W, cmd2W, go, failCur, trig, bad;
    cfm_src_e newSrc; // source from config_command_1
    cfm_role_e newRole; // role from config_command_1
    assign pin = st_r.sync2;
    // compat clock rate table
    always_comb
    begin
        rate = st_r.config_command_1[`CFM_C1_RATE];
        // scbus stops at 1024 periods
        if (st_r.config_command_2[`CFM_C2_SCBUS] && rate == 2'b11)
            rate = 2'b10;
        unique case (rate)
            2'b00: cmpLate = 16'(`CFM_LATE(`CFM_C2_PS, `CFM_CMP_TOL_NS));
            2'b01: cmpLate = 16'(`CFM_LATE(`CFM_C4_PS, `CFM_CMP_TOL_NS));
            2'b10: cmpLate = 16'(`CFM_LATE(`CFM_C8_PS, `CFM_CMP_TOL_NS));
            2'b11: cmpLate = 16'(`CFM_LATE(`CFM_C16_PS, `CFM_CMP_TOL_NS));
        endcase
        cmpCnt = `CFM_FRAME_C2 << rate;
    end
    // monitors run once setup is complete
    assign busEn = st_r.configured;
    assign netEn = st_r.configured;
    // compat frame only against the live reference
    assign cmpEn = st_r.configured && ((st_r.role == ROLE_SLAVE)
        ? (st_r.src == SRC_BUSA || st_r.src == SRC_BUSB)
        : (st_r.src == SRC_MAIN || st_r.src == SRC_SEC));
    // clock set a
    cfm_clk_mon monA (
        .clk(clk), .rst(rst), .ce(ce), .en(busEn),
        .clkLvl(pin.busClkA), .frmLvl(pin.busFrmA), .useFrame(1'b1),
        .lateLim(BUS_LATE), .expCnt(`CFM_FRAME_C8), .fail(fA), .healthy()
    );
    // clock set b
    cfm_clk_mon monB (
        .clk(clk), .rst(rst), .ce(ce), .en(busEn),
        .clkLvl(pin.busClkB), .frmLvl(pin.busFrmB), .useFrame(1'b1),
        .lateLim(BUS_LATE), .expCnt(`CFM_FRAME_C8), .fail(fB), .healthy()
    );
    // compat clock and frame
    cfm_clk_mon monC (
        .clk(clk), .rst(rst), .ce(ce), .en(cmpEn),
        .clkLvl(pin.compatClk), .frmLvl(pin.compatFrm), .useFrame(1'b1),
        .lateLim(cmpLate), .expCnt(cmpCnt), .fail(fC), .healthy()
    );
    cfm_clk_mon monNP (
        .clk(clk), .rst(rst), .ce(ce), .en(netEn),
        .clkLvl(pin.netPrim), .frmLvl(1'b1), .useFrame(1'b0),
        .lateLim(NET_LATE), .expCnt(12'h000), .fail(fNP), .healthy(hNP)
    );
    cfm_clk_mon monNS (
        .clk(clk), .rst(rst), .ce(ce), .en(netEn),
        .clkLvl(pin.netSec), .frmLvl(1'b1), .useFrame(1'b0),
        .lateLim(NET_LATE), .expCnt(12'h000), .fail(fNS), .healthy()
    );
    // main next-state logic
    always_comb
    begin
        st_nxt = st_r;
        // two-stage pin synchroniser
        st_nxt.sync1 = pins;
        st_nxt.sync2 = st_r.sync1;
        cmd1W = wr && addr == `CFM_A_CONFIG_COMMAND_1;
        cmd2W = wr && addr == `CFM_A_CONFIG_COMMAND_2;
        go = cmd1W && wdata[`CFM_C1_GO];
        newSrc = cfm_src_e'(wdata[`CFM_C1_SRC]);
        newRole = cfm_role_e'(wdata[`CFM_C1_ROLE]);
        // master must not use slave path
        // slave must not use master reference
        bad = (newRole == ROLE_MASTER && (newSrc == SRC_BUSA || newSrc == SRC_BUSB))
            || (newRole == ROLE_SLAVE && (newSrc == SRC_MAIN || newSrc == SRC_SEC));
        // status: write one clears, set wins
        st_nxt.st1 = st_r.st1 & ~((wr && addr == `CFM_A_ST1) ? wdata : 8'h00);
        st_nxt.st2 = st_r.st2 & ~((wr && addr == `CFM_A_ST2) ? wdata : 8'h00);
        st_nxt.st1[`CFM_S1_A] = st_nxt.st1[`CFM_S1_A] | fA;
        st_nxt.st1[`CFM_S1_B] = st_nxt.st1[`CFM_S1_B] | fB;
        st_nxt.st1[`CFM_S1_CMP] = st_nxt.st1[`CFM_S1_CMP] | fC;
        st_nxt.st1[`CFM_S1_NP] = st_nxt.st1[`CFM_S1_NP] | fNP;
        st_nxt.st1[`CFM_S1_NS] = st_nxt.st1[`CFM_S1_NS] | fNS;
        if (wr && addr == `CFM_A_MASK)
            st_nxt.mask = wdata;
        if (cmd1W)
            st_nxt.config_command_1 = {wdata[7:6], 1'b0, wdata[4:0]};
        if (cmd2W)
        begin
            // command bits act once; only settings are kept
            st_nxt.config_command_2 = wdata & `CFM_C2_KEEP;
            // soft reset only flips the outward flag
            if (wdata[`CFM_C2_SWRST])
                st_nxt.swRst = !st_r.swRst;
        end
        if (cmd2W && wdata[`CFM_C2_EXTF])
        begin
            st_nxt.lockRun = 1'b1;
            st_nxt.lockDone = 1'b0;
            st_nxt.lockCnt = '0;
        end
        else if (st_r.lockRun)
        begin
            if (st_r.lockCnt == LOCK_LAST)
            begin
                st_nxt.lockRun = 1'b0;
                st_nxt.lockDone = 1'b1;
            end
            else
                st_nxt.lockCnt = st_r.lockCnt + 18'h00001;
        end
        // failure that the current role falls back from
        failCur = (st_r.role == ROLE_MASTER) ? (fNP && st_r.src == SRC_MAIN)
            : (fA && st_r.src == SRC_BUSA);
        trig = (st_r.config_command_2[`CFM_C2_AUTO] && failCur)
            || (cmd2W && wdata[`CFM_C2_MFB] && (st_r.failPend || failCur));
        // fallback machine; the mux switches in one clean edge of the
        // registered select, which is what keeps switched data intact
        unique case (st_r.fb)
            FB_IDLE:
            begin
                st_nxt.failPend = 1'b0;
                if (st_r.configured && st_r.config_command_2[`CFM_C2_FBEN])
                    st_nxt.fb = FB_WATCH;
            end
            FB_WATCH:
            begin
                if (failCur)
                    st_nxt.failPend = 1'b1;
                if (!st_r.config_command_2[`CFM_C2_FBEN])
                    st_nxt.fb = FB_IDLE;
                else if (trig)
                begin
                    st_nxt.st2[`CFM_S2_FELL] = 1'b1;
                    st_nxt.failPend = 1'b0;
                    if (st_r.role == ROLE_MASTER)
                    begin
                        st_nxt.src = SRC_SEC;
                        st_nxt.fb = FB_FALLEN;
                    end
                    else
                    begin
                        st_nxt.src = (st_r.role == ROLE_SLAVE) ? SRC_BUSB : SRC_SEC;
                        st_nxt.config_command_2[`CFM_C2_FBEN] = 1'b0;
                        st_nxt.fb = FB_IDLE;
                    end
                end
            end
            FB_FALLEN:
            begin
                // return to main, auto or by command
                if ((st_r.config_command_2[`CFM_C2_ARET] && hNP) || (cmd2W && wdata[`CFM_C2_MRET]))
                begin
                    st_nxt.src = SRC_MAIN;
                    st_nxt.st2[`CFM_S2_BACK] = 1'b1;
                    st_nxt.fb = FB_WATCH;
                end
                else if (!st_r.config_command_2[`CFM_C2_FBEN])
                    st_nxt.fb = FB_IDLE;
            end
            default:
                st_nxt.fb = FB_IDLE;
        endcase
        // role command closes setup and starts checks
        if (go)
        begin
            st_nxt.failPend = 1'b0;
            st_nxt.fb = FB_IDLE;
            if (bad)
            begin
                // fall back to oscillator, wipe setup
                st_nxt.src = SRC_INT;
                st_nxt.role = ROLE_NONE;
                st_nxt.configured = 1'b0;
                st_nxt.config_command_1 = 8'h00;
                st_nxt.config_command_2 = 8'h00;
                st_nxt.st1[`CFM_S1_WRONG] = 1'b1;
            end
            else
            begin
                st_nxt.src = newSrc;
                st_nxt.role = newRole;
                st_nxt.configured = newRole != ROLE_NONE;
            end
        end
        // read data stand one cycle only
        st_nxt.rdata = 8'h00;
        if (rd)
        begin
            unique case (addr)
                `CFM_A_CONFIG_COMMAND_1: st_nxt.rdata = st_r.config_command_1;
                `CFM_A_CONFIG_COMMAND_2: st_nxt.rdata = st_r.config_command_2;
                `CFM_A_ST1: st_nxt.rdata = st_r.st1;
                `CFM_A_ST2: st_nxt.rdata = st_r.st2;
                `CFM_A_MASK: st_nxt.rdata = st_r.mask;
                `CFM_A_STATE: st_nxt.rdata = {st_r.fb, st_r.lockDone, st_r.configured,
                    1'b0, st_r.src};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end
    // state register; reset selects the internal source
    always_ff @(posedge clk)
    begin
        if (rst)
            st_r <= '0;
        else if (ce)
            st_r <= st_nxt;
    end
    // outputs
    assign rdata = st_r.rdata;
    assign gen.src = st_r.src;
    // bypass until locked, then fast clock
    assign gen.bypass = !st_r.lockDone;
    assign gen.fastClk = st_r.lockDone;
    assign gen.driveSetB = st_r.configured && st_r.role == ROLE_SECM;
    assign irq = |(st_r.st1[5:0] & ~st_r.mask[5:0]) | |(st_r.st2[1:0] & ~st_r.mask[7:6]);
    assign swResetActive = st_r.swRst;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_reset_src_int: assert property ($past(rst) |-> gen.src == SRC_INT && gen.bypass)
        else $error("reset did not select internal source");
    a_no_early_check: assert property ($rose(st_r.st1[`CFM_S1_WRONG]) |-> $past(go))
        else $error("source check without role command");
    a_master_bad_src: assert property (ce && go && newRole == ROLE_MASTER
        && newSrc == SRC_BUSA |=> st_r.st1[`CFM_S1_WRONG] && gen.src == SRC_INT)
        else $error("master on slave path not caught");
    a_slave_bad_src: assert property (ce && go && newRole == ROLE_SLAVE
        && newSrc == SRC_MAIN |=> st_r.st1[`CFM_S1_WRONG] && !st_r.configured
        && st_r.config_command_2 == 8'h00)
        else $error("slave on master reference not caught");
    a_fail_irq: assert property (ce && fA && !st_r.mask[`CFM_S1_A] |=> irq)
        else $error("unmasked failure gave no interrupt");
    a_status_sticky: assert property (ce && st_r.st1[`CFM_S1_B]
        && !(wr && addr == `CFM_A_ST1) |=> st_r.st1[`CFM_S1_B])
        else $error("status bit lost without clear");
    a_lock_switch: assert property (ce && cmd2W && wdata[`CFM_C2_EXTF]
        |=> gen.bypass && !gen.fastClk)
        else $error("frequency command did not bypass pll");
    a_slave_to_b: assert property (ce && st_r.fb == FB_WATCH && st_r.role == ROLE_SLAVE
        && st_r.config_command_2[`CFM_C2_FBEN] && st_r.config_command_2[`CFM_C2_AUTO] && fA
        && st_r.src == SRC_BUSA && !go |=> gen.src == SRC_BUSB
        && !st_r.config_command_2[`CFM_C2_FBEN] && st_r.st2[`CFM_S2_FELL])
        else $error("slave did not fall back to set b");
    a_master_to_sec: assert property (ce && st_r.fb == FB_WATCH
        && st_r.role == ROLE_MASTER && st_r.config_command_2[`CFM_C2_FBEN] && st_r.config_command_2[`CFM_C2_AUTO]
        && fNP && st_r.src == SRC_MAIN && !go |=> gen.src == SRC_SEC ##1 st_r.fb == FB_FALLEN)
        else $error("master did not fall back to secondary");
    a_swrst_keeps_src: assert property (ce && cmd2W && wdata == 8'h10 && !go
        && st_r.fb == FB_IDLE |=> $stable(gen.src) && $stable(st_r.role))
        else $error("soft reset disturbed clocking");
endmodule // clock_fallback_monitor

// ==== hw/cfm_defs.svh ====
/*
 * constants of the clock fallback monitor: timings, register map, fields.
 * assumes a 250 MHz block clock; included by the monitor source only.
 */
`ifndef CFM_DEFS_SVH
`define CFM_DEFS_SVH

// block clock
`define CFM_CLK_PS 4000
`define CFM_CLK_NS 4
// pll lock time
`define CFM_LOCK_NS 750000
// edge tolerances
`define CFM_BUS_TOL_NS 35
`define CFM_CMP_TOL_NS 40
`define CFM_NET_TOL_NS 80
// nominal periods
`define CFM_C2_PS 488281
`define CFM_C4_PS 244140
`define CFM_C8_PS 122070
`define CFM_C16_PS 61035
`define CFM_NET_PS 125000000
// latest expected edge, rounded down
`define CFM_LATE(p, t) (((p) + (t) * 1000) / `CFM_CLK_PS)
// periods per frame
`define CFM_FRAME_C8 12'h400
`define CFM_FRAME_C2 12'h100

// register addresses
`define CFM_A_CONFIG_COMMAND_1 3'h0
`define CFM_A_CONFIG_COMMAND_2 3'h1
`define CFM_A_ST1 3'h2
`define CFM_A_ST2 3'h3
`define CFM_A_MASK 3'h4
`define CFM_A_STATE 3'h5

// config_command_1 fields
`define CFM_C1_SRC 2:0
`define CFM_C1_ROLE 4:3
`define CFM_C1_GO 5
`define CFM_C1_RATE 7:6
// config_command_2 fields
`define CFM_C2_EXTF 0
`define CFM_C2_FBEN 1
`define CFM_C2_AUTO 2
`define CFM_C2_ARET 3
`define CFM_C2_SWRST 4
`define CFM_C2_MFB 5
`define CFM_C2_MRET 6
`define CFM_C2_SCBUS 7
// stored (non-command) bits of config_command_2
`define CFM_C2_KEEP 8'h8e

// clock_error_status_1 bits
`define CFM_S1_A 0
`define CFM_S1_B 1
`define CFM_S1_CMP 2
`define CFM_S1_NP 3
`define CFM_S1_NS 4
`define CFM_S1_WRONG 5
// clock_error_status_2 bits, masked by mask bits 7:6
`define CFM_S2_FELL 0
`define CFM_S2_BACK 1

`endif

// ==== hw/cfm_pkg.sv ====
/*
 * types of the clock fallback monitor.
 * assumes nothing beyond a systemverilog compiler.
 */
package cfm_pkg;

    // pll reference sources
    typedef enum logic [2:0] {
        SRC_INT = 3'b000,
        SRC_MAIN = 3'b001,
        SRC_SEC = 3'b010,
        SRC_BUSA = 3'b011,
        SRC_BUSB = 3'b100
    } cfm_src_e;

    // bus roles
    typedef enum logic [1:0] {
        ROLE_NONE = 2'b00,
        ROLE_MASTER = 2'b01,
        ROLE_SECM = 2'b10,
        ROLE_SLAVE = 2'b11
    } cfm_role_e;

    // fallback states
    typedef enum logic [1:0] {
        FB_IDLE = 2'b00,
        FB_WATCH = 2'b01,
        FB_FALLEN = 2'b10
    } cfm_fb_e;

    // monitored pins
    typedef struct packed {
        logic busClkA;
        logic busFrmA;
        logic busClkB;
        logic busFrmB;
        logic netPrim;
        logic netSec;
        logic compatClk;
        logic compatFrm;
    } cfm_pins_s;

    // clock generator control
    typedef struct packed {
        cfm_src_e src;
        logic bypass;
        logic fastClk;
        logic driveSetB;
    } cfm_gen_s;

    // per-clock monitor state
    typedef struct packed {
        logic prevClk;
        logic prevFrm;
        logic armed;
        logic framed;
        logic fail;
        logic [15:0] gap;
        logic [11:0] cnt;
    } cfm_mon_s;

    // top state
    typedef struct packed {
        cfm_pins_s sync1;
        cfm_pins_s sync2;
        logic [7:0] config_command_1;
        logic [7:0] config_command_2;
        logic [7:0] st1;
        logic [7:0] st2;
        logic [7:0] mask;
        logic [7:0] rdata;
        cfm_src_e src;
        cfm_role_e role;
        logic configured;
        logic lockRun;
        logic lockDone;
        logic [17:0] lockCnt;
        cfm_fb_e fb;
        logic failPend;
        logic swRst;
    } cfm_top_s;

endpackage

// ==== bench/cfm_far_boards.sv ====
/*
 * far-side model: the boards that drive both bus clock sets, the network
 * references and the compatibility clock and frame.
 * assumes the monitor samples these levels asynchronously to its own clock.
 */
`timescale 1ns/1ns

module cfm_far_boards (
    input wire logic killA,
    input wire logic shortA,
    input wire logic killNet,
    output cfm_pkg::cfm_pins_s pins
);
    import cfm_pkg::*;

    logic linkClk; // free-running 64 ns link clock
    logic [9:0] cntA; // bit periods in frame of set a
    logic [9:0] cnt; // bit periods for every other set

    // link clock runs free, as a live master drives it
    initial
    begin
        linkClk = 1'b0;
        cntA = 10'h000;
        cnt = 10'h000;
        forever #32 linkClk = ~linkClk;
    end

    // frame counters; frames are low for one period at the start
    always @(posedge linkClk)
    begin
        cnt <= cnt + 10'h001;
        cntA <= (shortA && cntA >= 10'h3e7) ? 10'h000 : cntA + 10'h001;
    end

    // a killed clock stands still low, like a dead driver behind a pull-down
    assign pins = '{busClkA: linkClk & ~killA, busFrmA: cntA != 10'h000,
        busClkB: linkClk, busFrmB: cnt != 10'h000, netPrim: linkClk & ~killNet,
        netSec: linkClk, compatClk: linkClk, compatFrm: cnt[7:0] != 8'h00};
endmodule // cfm_far_boards

// ==== bench/testbench.sv ====
/*
 * self-checking bench of the clock fallback monitor.
 * assumes the far-side model cfm_far_boards and a 250 MHz block clock.
 */
`timescale 1ns/1ns

module testbench;
    import cfm_pkg::*;

    localparam int LOCK = 50; // shortened pll lock count
    logic clk, rst, ce, wr, rd, irq, swResetActive, killA, shortA, killNet, rdSeen;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rnd;
    cfm_pins_s pins;
    cfm_gen_s gen;
    logic [7:0] expQ[$]; // expected read data, oldest first
    int fail_count, n_compared;

    clock_fallback_monitor #(.LOCK_CYCLES(LOCK), .NET_LATE_CYC(100)) uut (.clk(clk),
        .rst(rst), .ce(ce), .pins(pins), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .gen(gen), .irq(irq), .swResetActive(swResetActive));
    cfm_far_boards far (.killA(killA), .shortA(shortA), .killNet(killNet), .pins(pins));

    // 4 ns block clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk)
    begin
        rdSeen <= rd;
        if (rdSeen === 1'b1)
            chk("rdata", rdata, expQ.size() > 0 ? expQ.pop_front() : 8'hxx);
    end

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rdReg(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        expQ.push_back(exp);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // let the edge's updates land before looking
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // bounded wait; running out ends the run
    task automatic waitGen(input cfm_gen_s want, input int lim);
        int i;
        #1;
        for (i = 0; i < lim && gen !== want; i++)
            #4;
        chk("gen", {2'b00, gen}, {2'b00, want});
        if (gen !== want)
            test_done;
    endtask

    task automatic doReset;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        killA <= 1'b0;
        shortA <= 1'b0;
        killNet <= 1'b0;
    endtask

    // main sequence
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        killA = 1'b0;
        shortA = 1'b0;
        killNet = 1'b0;
        fail_count = 0;
        n_compared = 0;
        void'($urandom(32'h7a37));
        doReset;
        settle;
        chk("gen", {2'b00, gen}, 8'h04);
        rnd = 8'($urandom) & 8'h8e;
        wrReg(3'h1, rnd);
        wrReg(3'h6, 8'hff);
        rdReg(3'h1, rnd);
        rdReg(3'h6, 8'h00);
        wrReg(3'h1, 8'h00);
        wrReg(3'h0, 8'h2b);
        settle;
        chk("gen", {2'b00, gen}, 8'h04);
        chk("irq", {7'h00, irq}, 8'h01);
        rdReg(3'h2, 8'h20);
        rdReg(3'h0, 8'h00);
        wrReg(3'h4, 8'h20);
        settle;
        chk("irq", {7'h00, irq}, 8'h00);
        wrReg(3'h0, 8'h39);
        rdReg(3'h5, 8'h00);
        rdReg(3'h0, 8'h00);
        wrReg(3'h1, 8'h01);
        repeat (LOCK - 5) @(posedge clk);
        #1;
        chk("bypass", {7'h00, gen.bypass}, 8'h01);
        waitGen(6'b000010, 20);
        wrReg(3'h1, 8'h10);
        settle;
        chk("swrst", {7'h00, swResetActive}, 8'h01);
        chk("gen", {2'b00, gen}, 8'h02);
        // secondary master drives set b
        wrReg(3'h0, 8'h33);
        settle;
        chk("gen", {2'b00, gen}, 8'h1b);
        $display("test setup checks done");
        // slave on set a with auto fallback; host keeps to valid references
        @(posedge clk);
        doReset;
        wrReg(3'h0, 8'h3b);
        wrReg(3'h1, 8'h06);
        settle;
        chk("gen", {2'b00, gen}, 8'h1c);
        repeat (2 * 16384) @(posedge clk);
        #1;
        chk("gen", {2'b00, gen}, 8'h1c);
        rdReg(3'h2, 8'h00);
        shortA <= 1'b1;
        waitGen(6'b100100, 40000);
        rdReg(3'h2, 8'h01);
        $display("test frame count done");
        // primary master loses its network reference, then gets it back
        @(posedge clk);
        doReset;
        wrReg(3'h0, 8'h29);
        wrReg(3'h1, 8'h0e);
        repeat (2000) @(posedge clk);
        killNet <= 1'b1;
        waitGen(6'b010100, 200);
        rdReg(3'h2, 8'h08);
        killNet <= 1'b0;
        waitGen(6'b001100, 100);
        rdReg(3'h3, 8'h03);
        $display("test network fallback done");
        @(posedge clk);
        // host re-arms after the reset and a fresh setup
        doReset;
        wrReg(3'h0, 8'h3b);
        wrReg(3'h1, 8'h06);
        repeat (2000) @(posedge clk);
        killA <= 1'b1;
        waitGen(6'b100100, 100);
        chk("irq", {7'h00, irq}, 8'h01);
        rdReg(3'h3, 8'h01);
        wrReg(3'h3, 8'h01);
        rdReg(3'h3, 8'h00);
        repeat (3) @(posedge clk);
        $display("test clock loss done");
        test_done;
    end
endmodule // testbench
